// ---- ncb_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ncb_cfg.svh"
// Contract
// - drive address in T1, data later; only monitor lines while host owns bus
// - lowest address line low in T1 for a low-half byte transfer
// - middle address byte stays valid T1 through T4 for an 8-bit host
// - upper lines carry address in T1, then status 1,0,1,1
// - high-byte enable in T1, status bit seven later, monitor in host cycles
// - status bit seven equals high-byte enable in own cycles
// - cycle type: read 101, write 110, passive 111, others unused
// - bus request to CPU is one clock low pulse
// - after grant start own cycle next clock or forward grant
// - release pulse to CPU one clock after last cycle or master release
// - pass-through: request +1 clock, grant +2, release +1
// - master request while owning: grant at T4/T1, float bus
// - master release pulse ends tenure, bus reclaimed afterwards
// - exchange is three pulses and one dead clock
// - decode host queue status and mirror host queue
// - interrupt on unmasked exception while interrupts enabled
// - busy while unit runs and until exception cleared
// - wait states until ready
// - reset held four clocks, abandons all activity at once
// - detect host width after reset from high-byte enable line
module ncb_bus_if (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// multiplexed address/data
	input  wire logic [15:0]      muxed_addr_data_lines_in,
	output logic [15:0]           muxed_addr_data_lines_out,
	output logic [15:0]           muxed_addr_data_lines_oe,
	// upper address / status
	input  wire logic [3:0]       upper_address_status_lines_in,
	output logic [3:0]            upper_address_status_lines_out,
	output logic [3:0]            upper_address_status_lines_oe,
	input  wire logic             high_byte_enable_status_in,
	output logic                  high_byte_enable_status_out,
	output logic                  high_byte_enable_status_oe,
	input  wire logic [2:0]       cycle_type_status_in,
	output logic [2:0]            cycle_type_status_out,
	output logic [2:0]            cycle_type_status_oe,
	// request/grant pins
	input  wire logic             cpu_side_request_grant_in,
	output logic                  cpu_side_request_grant_out,
	output logic                  cpu_side_request_grant_oe,
	input  wire logic             master_side_request_grant_in,
	output logic                  master_side_request_grant_out,
	output logic                  master_side_request_grant_oe,
	// host status and handshake
	input  wire logic [1:0]       host_queue_status,
	input  wire logic             ready,
	output logic                  int_req,
	output logic                  busy,
	// numeric unit memory port
	input  wire logic             req_valid,
	input  wire ncb_pkg::ncb_req_t req,
	output logic                  req_ready,
	output logic                  rsp_valid,
	output logic [15:0]           rsp_data,
	// numeric unit status
	input  wire logic             neu_running,
	input  wire logic             exc_event,
	input  wire logic             exc_clear,
	input  wire logic             int_enable,
	// queue mirror
	output logic                  host_is_16,
	output logic [3:0]            queue_count,
	output logic                  queue_first,
	output logic                  queue_next,
	output logic                  queue_flush
);

	ncb_pkg::ncb_arb_t  arb;
	ncb_pkg::ncb_arb_t  next_arb;
	ncb_pkg::ncb_tst_t  ts;
	ncb_pkg::ncb_tst_t  next_ts;
	ncb_pkg::ncb_req_t  cur;
	ncb_pkg::ncb_req_t  next_cur;
	ncb_pkg::ncb_pins_t pins;
	logic               mreq;
	logic               fin;
	logic               exc_flag;
	logic               det_done;
	logic [2:0]         ct_prev;

	// pin values for a T-state; registered one cycle ahead
	function automatic ncb_pkg::ncb_pins_t bus_pins(
		input ncb_pkg::ncb_tst_t t,
		input ncb_pkg::ncb_req_t c,
		input logic              drv,
		input logic              h16
	);
		ncb_pkg::ncb_pins_t p;
		p.ad = c.addr[15:0];
		p.ad_oe = 16'h0000;
		p.ua = c.addr[19:16];
		p.hbe = c.bhe_n;
		p.ct = `NCB_CT_PASS;
		p.drv = drv;
		if (t == ncb_pkg::T_1) begin
			p.ad_oe = 16'hFFFF;
			p.ct = c.write ? `NCB_CT_WRITE : `NCB_CT_READ;
		end else if (t != ncb_pkg::T_IDLE) begin
			p.ua = `NCB_ST_HI;
			p.ad[7:0] = c.wdata[7:0];
			// 8-bit host keeps address on the middle byte
			if (h16) begin
				p.ad[15:8] = c.wdata[15:8];
			end
			if (c.write) begin
				p.ad_oe = 16'hFFFF;
			end else begin
				p.ad_oe = h16 ? 16'h0000 : 16'hFF00;
			end
			if (t == ncb_pkg::T_2) begin
				p.ct = c.write ? `NCB_CT_WRITE : `NCB_CT_READ;
			end
		end
		if (!drv) begin
			p.ad_oe = 16'h0000;
			p.ct = `NCB_CT_PASS;
		end
		return p;
	endfunction : bus_pins

	// open-drain request/grant decode
	wire cpu_pull = (arb == ncb_pkg::ARB_REQ_OWN) || (arb == ncb_pkg::ARB_REL)
		|| (arb == ncb_pkg::ARB_PREQ) || (arb == ncb_pkg::ARB_PREL);
	wire mst_pull = (arb == ncb_pkg::ARB_MGNT) || (arb == ncb_pkg::ARB_PGNT);
	// our own pull must not look like a pulse from the far side
	wire cpu_low = !cpu_side_request_grant_in && !cpu_pull;
	wire mst_low = !master_side_request_grant_in && !mst_pull;
	wire t_free = (ts == ncb_pkg::T_IDLE);
	wire done = (ts == ncb_pkg::T_4);
	wire done_last = done && cur.last;
	wire own_now = (arb == ncb_pkg::ARB_OWN)
		|| ((arb == ncb_pkg::ARB_WAIT_OWN) && cpu_low);
	wire take = req_valid && req_ready;
	wire next_drv = (next_arb == ncb_pkg::ARB_OWN) && (next_ts != ncb_pkg::T_IDLE);

	assign req_ready = t_free && own_now && !mreq && !fin;
	assign cpu_side_request_grant_out = 1'b0;
	assign cpu_side_request_grant_oe = cpu_pull;
	assign master_side_request_grant_out = 1'b0;
	assign master_side_request_grant_oe = mst_pull;
	assign muxed_addr_data_lines_out = pins.ad;
	assign muxed_addr_data_lines_oe = pins.ad_oe;
	assign upper_address_status_lines_out = pins.ua;
	assign upper_address_status_lines_oe = {4{pins.drv}};
	assign high_byte_enable_status_out = pins.hbe;
	assign high_byte_enable_status_oe = pins.drv;
	assign cycle_type_status_out = pins.ct;
	assign cycle_type_status_oe = {3{pins.drv}};

	// T-state sequencer
	always_comb begin
		next_ts = ts;
		next_cur = cur;
		case (ts)
			ncb_pkg::T_IDLE: if (take) begin
				next_ts = ncb_pkg::T_1;
				next_cur = req;
			end
			ncb_pkg::T_1: next_ts = ncb_pkg::T_2;
			ncb_pkg::T_2: next_ts = ncb_pkg::T_3;
			ncb_pkg::T_3: next_ts = ready ? ncb_pkg::T_4 : ncb_pkg::T_W;
			ncb_pkg::T_W: next_ts = ready ? ncb_pkg::T_4 : ncb_pkg::T_W;
			ncb_pkg::T_4: next_ts = ncb_pkg::T_IDLE;
			default: next_ts = ncb_pkg::T_IDLE;
		endcase
	end

	// bus arbitration between CPU, self and attached master
	always_comb begin
		next_arb = arb;
		case (arb)
			ncb_pkg::ARB_IDLE: begin
				if (mst_low) begin
					next_arb = ncb_pkg::ARB_PREQ;
				end else if (req_valid) begin
					next_arb = ncb_pkg::ARB_REQ_OWN;
				end
			end
			ncb_pkg::ARB_REQ_OWN: next_arb = ncb_pkg::ARB_WAIT_OWN;
			ncb_pkg::ARB_WAIT_OWN: if (cpu_low) next_arb = ncb_pkg::ARB_OWN;
			ncb_pkg::ARB_OWN: begin
				if (mreq && (done || t_free)) begin
					next_arb = ncb_pkg::ARB_MGNT;
				end else if (done_last || (t_free && fin)) begin
					next_arb = ncb_pkg::ARB_REL;
				end
			end
			ncb_pkg::ARB_MGNT: next_arb = ncb_pkg::ARB_MACK;
			ncb_pkg::ARB_MACK: if (mst_low) next_arb = ncb_pkg::ARB_DEAD_OWN;
			ncb_pkg::ARB_DEAD_OWN: next_arb = ncb_pkg::ARB_OWN;
			ncb_pkg::ARB_REL: next_arb = ncb_pkg::ARB_DEAD;
			ncb_pkg::ARB_DEAD: next_arb = ncb_pkg::ARB_IDLE;
			ncb_pkg::ARB_PREQ: next_arb = ncb_pkg::ARB_PWAIT;
			ncb_pkg::ARB_PWAIT: if (cpu_low) next_arb = ncb_pkg::ARB_PDLY;
			ncb_pkg::ARB_PDLY: next_arb = ncb_pkg::ARB_PGNT;
			ncb_pkg::ARB_PGNT: next_arb = ncb_pkg::ARB_PTEN;
			ncb_pkg::ARB_PTEN: if (mst_low) next_arb = ncb_pkg::ARB_PREL;
			ncb_pkg::ARB_PREL: next_arb = ncb_pkg::ARB_DEAD;
			default: next_arb = ncb_pkg::ARB_IDLE;
		endcase
	end

	// queue mirror
	wire       qs_first = (host_queue_status == `NCB_QS_FIRST);
	wire       qs_next = (host_queue_status == `NCB_QS_NEXT);
	wire       qs_flush = (host_queue_status == `NCB_QS_FLUSH);
	wire       fetch = !pins.drv && (cycle_type_status_in == `NCB_CT_FETCH)
		&& (ct_prev == `NCB_CT_PASS);
	wire [3:0] q_inc = host_is_16 ? `NCB_QINC_16 : `NCB_QINC_8;
	wire [3:0] q_add = fetch ? q_inc : 4'h0;
	wire       q_dec = (qs_first || qs_next) && (queue_count != 4'h0);
	wire [3:0] q_sum = queue_count + q_add - {3'h0, q_dec};
	wire [3:0] q_cap = host_is_16 ? `NCB_QLEN_16 : `NCB_QLEN_8;
	wire [3:0] next_q = qs_flush ? 4'h0 : ((q_sum > q_cap) ? q_cap : q_sum);
	// set wins over clear so no exception is lost
	wire       next_exc = exc_event || (exc_flag && !exc_clear);

	// sync reset drops every activity in the same edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			arb <= ncb_pkg::ARB_IDLE;
			ts <= ncb_pkg::T_IDLE;
			cur <= '0;
			pins <= '0;
			mreq <= 1'b0;
			fin <= 1'b0;
		end else begin
			arb <= next_arb;
			ts <= next_ts;
			cur <= next_cur;
			pins <= bus_pins(next_ts, next_cur, next_drv, host_is_16);
			mreq <= (arb == ncb_pkg::ARB_OWN) && (mst_low || mreq);
			fin <= (arb != ncb_pkg::ARB_REL) && (fin || done_last);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
		end else begin
			rsp_valid <= done && !cur.write;
			if (done && !cur.write) begin
				rsp_data <= muxed_addr_data_lines_in;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			exc_flag <= 1'b0;
			busy <= 1'b0;
			int_req <= 1'b0;
		end else begin
			exc_flag <= next_exc;
			busy <= neu_running || next_exc;
			int_req <= int_enable && next_exc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			det_done <= 1'b0;
			host_is_16 <= 1'b0;
			queue_count <= 4'h0;
			queue_first <= 1'b0;
			queue_next <= 1'b0;
			queue_flush <= 1'b0;
			ct_prev <= `NCB_CT_PASS;
		end else begin
			det_done <= 1'b1;
			// a 16-bit host holds high-byte enable low after reset
			if (!det_done) begin
				host_is_16 <= !high_byte_enable_status_in;
			end
			queue_count <= next_q;
			queue_first <= qs_first;
			queue_next <= qs_next;
			queue_flush <= qs_flush;
			ct_prev <= cycle_type_status_in;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_st_hi;
		pins.drv && (ts inside {ncb_pkg::T_2, ncb_pkg::T_3, ncb_pkg::T_W, ncb_pkg::T_4})
			|-> upper_address_status_lines_out == `NCB_ST_HI;
	endproperty
	a_st_hi: assert property (p_st_hi) else $error("status S6..S3 wrong");
	property p_s7;
		pins.drv |-> high_byte_enable_status_out == cur.bhe_n;
	endproperty
	a_s7: assert property (p_s7) else $error("S7 differs from byte enable");
	property p_ct;
		cycle_type_status_oe[0] |-> cycle_type_status_out inside {3'h5, 3'h6, 3'h7};
	endproperty
	a_ct: assert property (p_ct) else $error("unused cycle type driven");
	property p_rq_one;
		cpu_side_request_grant_oe |=> !cpu_side_request_grant_oe;
	endproperty
	a_rq_one: assert property (p_rq_one) else $error("cpu pulse too wide");
	property p_own_go;
		arb == ncb_pkg::ARB_WAIT_OWN && cpu_low && req_valid |=> ts == ncb_pkg::T_1;
	endproperty
	a_own_go: assert property (p_own_go) else $error("no T1 after grant");
	property p_rel;
		arb == ncb_pkg::ARB_OWN && done_last && !mreq |=> cpu_side_request_grant_oe;
	endproperty
	a_rel: assert property (p_rel) else $error("release not one clock after");
	property p_pass;
		arb == ncb_pkg::ARB_PWAIT && cpu_low |-> ##2 master_side_request_grant_oe;
	endproperty
	a_pass: assert property (p_pass) else $error("grant pass delay wrong");
	property p_float;
		arb == ncb_pkg::ARB_MGNT |-> muxed_addr_data_lines_oe == 16'h0000
			&& !pins.drv ##1 (!pins.drv throughout (arb == ncb_pkg::ARB_MACK)[*1]);
	endproperty
	a_float: assert property (p_float) else $error("bus not floated at grant");
	property p_dead;
		$fell(cpu_side_request_grant_oe) && arb == ncb_pkg::ARB_DEAD
			|-> !master_side_request_grant_oe ##1 arb == ncb_pkg::ARB_IDLE;
	endproperty
	a_dead: assert property (p_dead) else $error("no dead clock");
	property p_wait;
		ts == ncb_pkg::T_3 && !ready |=> ts == ncb_pkg::T_W;
	endproperty
	a_wait: assert property (p_wait) else $error("missing wait state");
	property p_int;
		exc_event && int_enable |=> int_req && busy;
	endproperty
	a_int: assert property (p_int) else $error("interrupt not raised");
	property p_busy;
		exc_flag && !exc_clear |=> busy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy dropped with exception");
	property p_flush;
		host_queue_status == `NCB_QS_FLUSH |=> queue_count == 4'h0 && queue_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("queue not flushed");

	property p_cv_write;
		ts == ncb_pkg::T_4 && cur.write;
	endproperty
	c_cv_write: cover property (p_cv_write);
	property p_cv_pass;
		arb == ncb_pkg::ARB_PGNT;
	endproperty
	c_cv_pass: cover property (p_cv_pass);
	property p_cv_take;
		arb == ncb_pkg::ARB_MACK ##1 arb == ncb_pkg::ARB_DEAD_OWN;
	endproperty
	c_cv_take: cover property (p_cv_take);
	property p_cv_wait;
		ts == ncb_pkg::T_W;
	endproperty
	c_cv_wait: cover property (p_cv_wait);

endmodule : ncb_bus_if
`default_nettype wire

// ---- ncb_cfg.svh ----
`ifndef NCB_CFG_SVH
`define NCB_CFG_SVH
// status lines S6..S3 in own cycles after T1
`define NCB_ST_HI 4'hB
// cycle type codes on S2..S0
`define NCB_CT_READ 3'h5
`define NCB_CT_WRITE 3'h6
`define NCB_CT_PASS 3'h7
`define NCB_CT_FETCH 3'h4
// host queue status codes
`define NCB_QS_NOP 2'h0
`define NCB_QS_FIRST 2'h1
`define NCB_QS_FLUSH 2'h2
`define NCB_QS_NEXT 2'h3
// mirrored queue lengths by host width
`define NCB_QLEN_16 4'h6
`define NCB_QLEN_8 4'h4
`define NCB_QINC_16 4'h2
`define NCB_QINC_8 4'h1
// least reset hold, in clocks
`define NCB_RESET_MIN_CLK 4
`endif

// ---- ncb_pkg.sv ----
`default_nettype none
package ncb_pkg;
	typedef enum logic [2:0] {
		T_IDLE, T_1, T_2, T_3, T_W, T_4
	} ncb_tst_t;

	typedef enum logic [3:0] {
		ARB_IDLE, ARB_REQ_OWN, ARB_WAIT_OWN, ARB_OWN,
		ARB_REL, ARB_DEAD, ARB_MGNT, ARB_MACK, ARB_DEAD_OWN,
		ARB_PREQ, ARB_PWAIT, ARB_PDLY, ARB_PGNT, ARB_PTEN, ARB_PREL
	} ncb_arb_t;

	typedef struct packed {
		logic        write;
		logic        last;
		logic        bhe_n;
		logic [19:0] addr;
		logic [15:0] wdata;
	} ncb_req_t;

	typedef struct packed {
		logic [15:0] ad;
		logic [15:0] ad_oe;
		logic [3:0]  ua;
		logic        hbe;
		logic [2:0]  ct;
		logic        drv;
	} ncb_pins_t;
endpackage : ncb_pkg
`default_nettype wire

// ---- ncb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ncb_host_model #(
	parameter int          GNT_DLY  = 3,
	parameter logic [15:0] MEM_WORD = 16'h5AC3
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// request/grant pin as seen on the wire
	input  wire logic        cpu_pin,
	output logic             cpu_pull,
	// memory side of the shared bus
	input  wire logic [2:0]  ct_out,
	input  wire logic        ct_oe,
	input  wire logic [15:0] ad_level,
	input  wire logic [3:0]  waits,
	output logic             ready,
	output logic [15:0]      mem_drv
);
	logic [1:0]  st;
	logic [3:0]  cnt;
	logic [3:0]  wcnt;
	logic        rd_cyc;
	logic [15:0] last_level;
	wire         own_active = ct_oe && (ct_out != 3'h7);

	// the cpu grants a seen request after a delay, then waits for the release
	always_ff @(posedge clk_sys) begin
		cpu_pull <= 1'b0;
		if (!rst_n) begin
			st <= 2'd0;
			cnt <= 4'h0;
		end else begin
			case (st)
				2'd0: if (!cpu_pin) begin
					st <= 2'd1;
					cnt <= 4'h0;
				end
				2'd1: begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'(GNT_DLY - 1)) begin
						cpu_pull <= 1'b1;
						st <= 2'd2;
					end
				end
				2'd2: if (!cpu_pin && !cpu_pull) st <= 2'd3;
				default: st <= 2'd0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		last_level <= ad_level;
		if (!rst_n) begin
			wcnt <= 4'hF;
			rd_cyc <= 1'b0;
		end else if (own_active) begin
			wcnt <= 4'h0;
			rd_cyc <= (ct_out == 3'h5);
		end else if (wcnt != 4'hF) begin
			wcnt <= wcnt + 4'h1;
		end
	end

	assign ready = (wcnt >= waits);
	// released lines show the inverse of their last level, so stale data never passes
	assign mem_drv = (rd_cyc && wcnt <= waits + 4'h1) ? MEM_WORD : ~last_level;
endmodule : ncb_host_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_top;
	localparam logic [15:0] MEM_WORD = 16'h5AC3;
	logic                clk_sys = 1'b0;
	logic                rst_n = 1'b0;
	logic [15:0]         ad_out, ad_oe, mem_drv;
	logic [3:0]          ua_out, ua_oe, waits = 4'h0;
	logic [2:0]          ct_out, ct_oe, host_ct = 3'h7;
	logic                hbe_out, hbe_oe, hbe_host = 1'b0, cpu_out, cpu_oe, mst_out, mst_oe, cpu_pull, mst_pull = 1'b0;
	logic [1:0]          qs = 2'h0;
	logic                ready, int_req, busy, req_ready, rsp_valid, host_is_16;
	logic                req_valid = 1'b0, neu_running = 1'b0, exc_event = 1'b0, exc_clear = 1'b0, int_enable = 1'b0;
	logic [15:0]         rsp_data;
	logic [3:0]          queue_count;
	logic                queue_first, queue_next, queue_flush;
	ncb_pkg::ncb_req_t   req = '0;
	int                  fail_count = 0;
	int                  checked = 0;
	// bus wires: ad_lvl takes driven bits, else mem_drv; request/grant pins low while anybody pulls
	wire logic [15:0]    ad_lvl = (ad_oe & ad_out) | (~ad_oe & mem_drv);
	wire logic           cpu_pin = !((cpu_oe && !cpu_out) || cpu_pull);
	wire logic           mst_pin = !((mst_oe && !mst_out) || mst_pull);

	always #20 clk_sys = ~clk_sys;

	ncb_bus_if DUT (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.muxed_addr_data_lines_in(ad_lvl), .muxed_addr_data_lines_out(ad_out), .muxed_addr_data_lines_oe(ad_oe),
		.upper_address_status_lines_in(ua_oe[0] ? ua_out : 4'hF), .upper_address_status_lines_out(ua_out),
		.upper_address_status_lines_oe(ua_oe), .high_byte_enable_status_in(hbe_oe ? hbe_out : hbe_host),
		.high_byte_enable_status_out(hbe_out), .high_byte_enable_status_oe(hbe_oe),
		.cycle_type_status_in(ct_oe[0] ? ct_out : host_ct), .cycle_type_status_out(ct_out), .cycle_type_status_oe(ct_oe),
		.cpu_side_request_grant_in(cpu_pin), .cpu_side_request_grant_out(cpu_out), .cpu_side_request_grant_oe(cpu_oe),
		.master_side_request_grant_in(mst_pin), .master_side_request_grant_out(mst_out),
		.master_side_request_grant_oe(mst_oe), .host_queue_status(qs), .ready(ready), .int_req(int_req), .busy(busy),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.neu_running(neu_running), .exc_event(exc_event), .exc_clear(exc_clear), .int_enable(int_enable),
		.host_is_16(host_is_16), .queue_count(queue_count), .queue_first(queue_first), .queue_next(queue_next),
		.queue_flush(queue_flush)
	);

	ncb_host_model #(.GNT_DLY(3), .MEM_WORD(MEM_WORD)) host (
		.clk_sys(clk_sys), .rst_n(rst_n), .cpu_pin(cpu_pin), .cpu_pull(cpu_pull), .ct_out(ct_out), .ct_oe(ct_oe[0]),
		.ad_level(ad_lvl), .waits(waits), .ready(ready), .mem_drv(mem_drv)
	);

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic xfer(input logic wr, input logic lst, input logic [19:0] a, input logic [15:0] d, input int w);
		int i;
		req = '{write: wr, last: lst, bhe_n: hbe_host, addr: a, wdata: d};
		req_valid = 1'b1;
		waits = 4'(w);
		for (i = 0; i < 40 && req_ready !== 1'b1; i++) cyc(1);
		`CHK(req_ready, 1'b1)
		cyc(1);
		req_valid = 1'b0;
		`CHK(ad_out, a[15:0])
		`CHK(ua_out, a[19:16])
		`CHK(ct_out, wr ? 3'h6 : 3'h5)
		`CHK(hbe_out, hbe_host)
		cyc(1);
		`CHK(ua_out, 4'hB)
		`CHK(ad_oe, wr ? 16'hFFFF : (hbe_host ? 16'hFF00 : 16'h0000))
		if (wr) `CHK(ad_out, d)
		cyc(1);
		`CHK(ct_out, 3'h7)
		for (i = 0; i < w; i++) begin
			cyc(1);
			`CHK(rsp_valid, 1'b0)
		end
		cyc(1);
		`CHK(hbe_out, hbe_host)
		if (hbe_host) `CHK(ad_out[15:8], a[15:8])
		cyc(1);
		if (!wr) `CHK(rsp_valid, 1'b1)
		if (!wr) `CHK(rsp_data[7:0], MEM_WORD[7:0])
		if (!wr && !hbe_host) `CHK(rsp_data[15:8], MEM_WORD[15:8])
		`CHK(cpu_oe, lst)
	endtask : xfer

	task automatic test_own();
		int i;
		req = '{write: 1'b0, last: 1'b0, bhe_n: 1'b0, addr: 20'h3A5C6, wdata: 16'h0000};
		req_valid = 1'b1;
		cyc(1);
		`CHK(cpu_oe, 1'b1)
		cyc(1);
		`CHK(cpu_oe, 1'b0)
		for (i = 0; i < 40 && req_ready !== 1'b1; i++) cyc(1);
		`CHK(cpu_pull, 1'b1)
		xfer(1'b0, 1'b0, 20'h3A5C6, 16'h0000, 2);
		// attached master takes the bus between our cycles
		mst_pull = 1'b1;
		cyc(1);
		mst_pull = 1'b0;
		cyc(1);
		`CHK(mst_oe, 1'b1)
		`CHK(ad_oe, 16'h0000)
		`CHK(ct_oe, 3'h0)
		cyc(1);
		`CHK(mst_oe, 1'b0)
		mst_pull = 1'b1;
		cyc(1);
		mst_pull = 1'b0;
		`CHK(cpu_oe, 1'b0)
		`CHK(req_ready, 1'b0)
		xfer(1'b1, 1'b1, 20'hC1234, 16'hBEEF, 0);
		cyc(1);
		`CHK(cpu_oe, 1'b0)
		`CHK(ad_oe, 16'h0000)
		$display("test own_cycles done");
	endtask : test_own

	task automatic test_pass();
		int i;
		// a pulse in the dead clock would be ignored
		cyc(1);
		mst_pull = 1'b1;
		cyc(1);
		mst_pull = 1'b0;
		`CHK(cpu_oe, 1'b1)
		for (i = 0; i < 40 && cpu_pull !== 1'b1; i++) cyc(1);
		cyc(1);
		`CHK(mst_oe, 1'b0)
		cyc(1);
		`CHK(mst_oe, 1'b1)
		cyc(3);
		mst_pull = 1'b1;
		cyc(1);
		mst_pull = 1'b0;
		`CHK(cpu_oe, 1'b1)
		cyc(1);
		`CHK(cpu_oe, 1'b0)
		cyc(2);
		$display("test pass_through done");
	endtask : test_pass

	task automatic test_queue();
		host_ct = 3'h4;
		cyc(1);
		host_ct = 3'h7;
		cyc(3);
		`CHK(queue_count, 4'h2)
		for (int c = 1; c < 4; c++) begin
			qs = 2'(c);
			cyc(1);
			qs = 2'h0;
			`CHK({queue_next, queue_flush, queue_first}, 3'(1 << (c - 1)))
		end
		cyc(1);
		`CHK(queue_count, 4'h0)
		$display("test queue done");
	endtask : test_queue

	task automatic test_exc();
		int_enable = 1'b1;
		exc_event = 1'b1;
		exc_clear = 1'b1;
		cyc(1);
		exc_event = 1'b0;
		`CHK(int_req, 1'b1)
		`CHK(busy, 1'b1)
		cyc(2);
		exc_clear = 1'b0;
		`CHK(busy, 1'b0)
		int_enable = 1'b0;
		exc_event = 1'b1;
		cyc(1);
		exc_event = 1'b0;
		`CHK(int_req, 1'b0)
		`CHK(busy, 1'b1)
		exc_clear = 1'b1;
		neu_running = 1'b1;
		cyc(2);
		exc_clear = 1'b0;
		`CHK(busy, 1'b1)
		neu_running = 1'b0;
		cyc(2);
		`CHK(busy, 1'b0)
		$display("test exception done");
	endtask : test_exc

	task automatic test_reset();
		int i;
		req = '{write: 1'b1, last: 1'b1, bhe_n: 1'b0, addr: 20'h00010, wdata: 16'h1357};
		req_valid = 1'b1;
		for (i = 0; i < 40 && req_ready !== 1'b1; i++) cyc(1);
		cyc(2);
		rst_n = 1'b0;
		req_valid = 1'b0;
		hbe_host = 1'b1;
		cyc(1);
		`CHK(ad_oe, 16'h0000)
		`CHK(ct_oe, 3'h0)
		cyc(3);
		rst_n = 1'b1;
		cyc(1);
		`CHK(host_is_16, 1'b0)
		$display("test mid_reset done");
	endtask : test_reset

	task automatic test_narrow();
		int i;
		req = '{write: 1'b0, last: 1'b1, bhe_n: 1'b1, addr: 20'h4B7A1, wdata: 16'h0000};
		req_valid = 1'b1;
		for (i = 0; i < 40 && req_ready !== 1'b1; i++) cyc(1);
		xfer(1'b0, 1'b1, 20'h4B7A1, 16'h0000, 1);
		cyc(2);
		`CHK(cpu_oe, 1'b0)
		$display("test narrow_host done");
	endtask : test_narrow

	initial begin
		cyc(3);
		`CHK(ad_oe, 16'h0000)
		`CHK(cpu_oe, 1'b0)
		rst_n = 1'b1;
		cyc(1);
		`CHK(host_is_16, 1'b1)
		test_own();
		test_pass();
		test_queue();
		test_exc();
		test_reset();
		test_narrow();
		report_and_stop();
	end

	// whole run takes well under a thousand cycles
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
